/* hw/dmio_top.sv */
/*
  Two 8-bit multi-function I/O ports behind an AHB-Lite register slave.
  Port A shares its pins with an LCD segment driver; port B shares its pins with
  converter, key wake-up, timer and external interrupt inputs. The LCD driver and the
  converter sit outside and run on hclk. Pin inputs are asynchronous to hclk.
*/
`timescale 1ns/100ps

module dmio_top #(
  parameter int PORT_W = 8
) (
  input  wire logic                hclk,                // Bus clock, 125 MHz
  input  wire logic                hresetn,             // Asynchronous reset, active low
  input  wire logic                hsel,                // Slave select
  input  wire logic [31:0]         haddr,               // Byte address
  input  wire logic [1:0]          htrans,              // Transfer type
  input  wire logic                hwrite,              // Write when high
  input  wire logic [2:0]          hsize,               // Transfer size, word only
  input  wire logic [31:0]         hwdata,              // Write data
  input  wire logic                hready,              // Bus ready
  output logic                     hreadyout,           // Slave ready
  output logic [31:0]              hrdata,              // Read data
  output logic                     hresp,               // Response, always OKAY
  input  wire logic [7:0]          pa_pin_in,           // Port A pin levels
  output dmio_pkg::dmio_pins_t     pa_pin,              // Port A drive and enable
  input  wire logic [7:0]          lcd_seg_data,        // Segment levels from LCD driver
  input  wire logic [7:0]          pb_pin_in,           // Port B pin levels
  output dmio_pkg::dmio_pins_t     pb_pin,              // Port B drive and enable
  output logic [7:0]               pb_digital_in,       // Gated input to timer and interrupts
  output logic [7:0]               pb_analog_sel,       // Pins released to analog/wake-up use
  output logic [2:0]               converter_channel_select // Converter channel
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************

  if (PORT_W != dmio_pkg::PORT_W) begin : g_bad_width
    $error("dmio_top: PORT_W must equal the package port width");
  end

  // The decode takes the bits above the index, so the index must end below bit 31
  if (dmio_pkg::ADDR_LSB + dmio_pkg::IDX_W > 31) begin : g_bad_index
    $error("dmio_top: register index does not fit below haddr bit 31");
  end

  if (dmio_pkg::CHSEL_W > PORT_W) begin : g_bad_chsel
    $error("dmio_top: channel field wider than a port byte");
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************

  function automatic dmio_pkg::dmio_sel_t decode_index(input logic [31:0] addr);
    logic [11:0] idx;
    idx = addr[dmio_pkg::ADDR_LSB +: dmio_pkg::IDX_W];
    if (addr[31:dmio_pkg::ADDR_LSB + dmio_pkg::IDX_W] != '0) begin
      return dmio_pkg::DMIO_SEL_NONE;
    end else if (idx == dmio_pkg::IDX_PA_LATCH) begin
      return dmio_pkg::DMIO_SEL_PA_LATCH;
    end else if (idx == dmio_pkg::IDX_PA_DIR) begin
      return dmio_pkg::DMIO_SEL_PA_DIR;
    end else if (idx == dmio_pkg::IDX_PA_SEG) begin
      return dmio_pkg::DMIO_SEL_PA_SEG;
    end else if (idx == dmio_pkg::IDX_PB_LATCH) begin
      return dmio_pkg::DMIO_SEL_PB_LATCH;
    end else if (idx == dmio_pkg::IDX_PB_DIR) begin
      return dmio_pkg::DMIO_SEL_PB_DIR;
    end else if (idx == dmio_pkg::IDX_PB_IE) begin
      return dmio_pkg::DMIO_SEL_PB_IE;
    end else if (idx == dmio_pkg::IDX_CONV) begin
      return dmio_pkg::DMIO_SEL_CONV;
    end else begin
      return dmio_pkg::DMIO_SEL_NONE;
    end
  endfunction

  // ****************************************************************
  // Per-bit read value of a port
  // ****************************************************************

  // Port A: output bits show the latch, segment bits read 0, else the pin
  function automatic logic [7:0] port_a_read(input logic [7:0] latch,
                                             input logic [7:0] dir,
                                             input logic [7:0] seg,
                                             input logic [7:0] pin);
    logic [7:0] val;
    val = '0;
    for (int i = 0; i < 8; i++) begin
      if (dir[i]) begin
        val[i] = latch[i];
      end else if (seg[i]) begin
        val[i] = 1'b0;
      end else begin
        val[i] = pin[i];
      end
    end
    return val;
  endfunction

  // Port B: output bits show the latch, disabled input bits read 0
  function automatic logic [7:0] port_b_read(input logic [7:0] latch,
                                             input logic [7:0] dir,
                                             input logic [7:0] ie,
                                             input logic [7:0] pin);
    logic [7:0] val;
    val = '0;
    for (int i = 0; i < 8; i++) begin
      if (dir[i]) begin
        val[i] = latch[i];
      end else if (ie[i]) begin
        val[i] = pin[i];
      end else begin
        val[i] = 1'b0;
      end
    end
    return val;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************

  dmio_pkg::dmio_state_t state_ff;
  dmio_pkg::dmio_state_t nxt_state;

  logic                  addr_phase;
  dmio_pkg::dmio_sel_t   addr_sel;
  logic [7:0]            pa_rd;
  logic [7:0]            pb_rd;

  assign addr_phase = hsel & hready & htrans[1];
  assign addr_sel   = decode_index(haddr);

  // hsize is not checked: byte and halfword accesses act on the whole register

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  always_comb begin
    nxt_state = state_ff;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Two-flop synchronisers; stage one feeds stage two only
    nxt_state.pa_sync1 = pa_pin_in;
    nxt_state.pa_sync2 = state_ff.pa_sync1;
    nxt_state.pb_sync1 = pb_pin_in;
    nxt_state.pb_sync2 = state_ff.pb_sync1;

    // ****************************************************************
    // Register write
    // ****************************************************************
    // Data phase of a write: store on the edge that ends it
    if (state_ff.ph_write) begin
      case (state_ff.ph_sel)
        dmio_pkg::DMIO_SEL_PA_LATCH: begin
          nxt_state.pa_latch = hwdata[7:0];
        end
        dmio_pkg::DMIO_SEL_PA_DIR: begin
          nxt_state.pa_dir = hwdata[7:0];
        end
        dmio_pkg::DMIO_SEL_PA_SEG: begin
          nxt_state.pa_seg = hwdata[7:0];
        end
        dmio_pkg::DMIO_SEL_PB_LATCH: begin
          nxt_state.pb_latch = hwdata[7:0];
        end
        dmio_pkg::DMIO_SEL_PB_DIR: begin
          nxt_state.pb_dir = hwdata[7:0];
        end
        dmio_pkg::DMIO_SEL_PB_IE: begin
          nxt_state.pb_ie = hwdata[7:0];
        end
        dmio_pkg::DMIO_SEL_CONV: begin
          nxt_state.chsel = hwdata[dmio_pkg::CHSEL_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // Address phase
    // ****************************************************************
    // Address phase: capture decode, prepare read data
    nxt_state.ph_write  = addr_phase & hwrite;
    nxt_state.ph_sel    = addr_phase ? addr_sel : dmio_pkg::DMIO_SEL_NONE;
    // No wait states: every register answers in its first data phase
    nxt_state.hreadyout = 1'b1;
    nxt_state.hresp     = dmio_pkg::HRESP_OKAY;

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Read from the post-write copy so a write then read back to back sees new data.
    // Input bits return the pin (0 on segment or disabled input bits), so a read-modify-write rewrites their latch.
    pa_rd = port_a_read(nxt_state.pa_latch, nxt_state.pa_dir, nxt_state.pa_seg,
                        state_ff.pa_sync2);
    pb_rd = port_b_read(nxt_state.pb_latch, nxt_state.pb_dir, nxt_state.pb_ie,
                        state_ff.pb_sync2);
    nxt_state.hrdata = '0;
    if (addr_phase && !hwrite) begin
      case (addr_sel)
        dmio_pkg::DMIO_SEL_PA_LATCH: begin
          nxt_state.hrdata = {24'h000000, pa_rd};
        end
        dmio_pkg::DMIO_SEL_PA_DIR: begin
          nxt_state.hrdata = {24'h000000, nxt_state.pa_dir};
        end
        dmio_pkg::DMIO_SEL_PA_SEG: begin
          nxt_state.hrdata = {24'h000000, nxt_state.pa_seg};
        end
        dmio_pkg::DMIO_SEL_PB_LATCH: begin
          nxt_state.hrdata = {24'h000000, pb_rd};
        end
        dmio_pkg::DMIO_SEL_PB_DIR: begin
          nxt_state.hrdata = {24'h000000, nxt_state.pb_dir};
        end
        dmio_pkg::DMIO_SEL_PB_IE: begin
          nxt_state.hrdata = {24'h000000, nxt_state.pb_ie};
        end
        dmio_pkg::DMIO_SEL_CONV: begin
          nxt_state.hrdata = {29'h00000000, nxt_state.chsel};
        end
        default: begin
          nxt_state.hrdata = '0;
        end
      endcase
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Pin drive follows the new register values on the same edge
    for (int i = 0; i < 8; i++) begin
      if (nxt_state.pa_seg[i]) begin
        nxt_state.pa_pins.drive[i] = lcd_seg_data[i];
        nxt_state.pa_pins.oe[i]    = 1'b1;
      end else begin
        nxt_state.pa_pins.drive[i] = nxt_state.pa_latch[i];
        nxt_state.pa_pins.oe[i]    = nxt_state.pa_dir[i];
      end
    end
    // Port B has no segment path: drive follows latch, enable follows direction
    nxt_state.pb_pins.drive = nxt_state.pb_latch;
    nxt_state.pb_pins.oe    = nxt_state.pb_dir;

    // ****************************************************************
    // Port B input gating
    // ****************************************************************
    // Digital input path is blocked on analog pins to keep them quiet
    nxt_state.pb_digital_in = ~nxt_state.pb_dir & nxt_state.pb_ie & state_ff.pb_sync2;
    nxt_state.pb_analog_sel = ~nxt_state.pb_dir & ~nxt_state.pb_ie;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff.pa_latch      <= dmio_pkg::RST_PA_LATCH;
      state_ff.pa_dir        <= dmio_pkg::RST_PA_DIR;
      state_ff.pa_seg        <= dmio_pkg::RST_PA_SEG;
      state_ff.pb_latch      <= dmio_pkg::RST_PB_LATCH;
      state_ff.pb_dir        <= dmio_pkg::RST_PB_DIR;
      state_ff.pb_ie         <= dmio_pkg::RST_PB_IE;
      state_ff.chsel         <= dmio_pkg::RST_CHSEL;
      // Synchronisers reset to 0, so pin bits read 0 until two samples are in
      state_ff.pa_sync1      <= 8'h00;
      state_ff.pa_sync2      <= 8'h00;
      state_ff.pb_sync1      <= 8'h00;
      state_ff.pb_sync2      <= 8'h00;
      state_ff.ph_write      <= 1'b0;
      state_ff.ph_sel        <= dmio_pkg::DMIO_SEL_NONE;
      state_ff.hrdata        <= 32'h00000000;
      state_ff.hreadyout     <= 1'b1;
      state_ff.hresp         <= dmio_pkg::HRESP_OKAY;
      state_ff.pa_pins       <= '{drive: 8'h00, oe: 8'h00};
      state_ff.pb_pins       <= '{drive: 8'h00, oe: 8'h00};
      state_ff.pb_digital_in <= 8'h00;
      state_ff.pb_analog_sel <= 8'h00;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign hreadyout                = state_ff.hreadyout;
  assign hrdata                   = state_ff.hrdata;
  assign hresp                    = state_ff.hresp;
  assign pa_pin                   = state_ff.pa_pins;
  assign pb_pin                   = state_ff.pb_pins;
  assign pb_digital_in            = state_ff.pb_digital_in;
  assign pb_analog_sel            = state_ff.pb_analog_sel;
  assign converter_channel_select = state_ff.chsel;

endmodule

/* hw/dmio_pkg.sv */
/*
  Constants, types and state layout for the dual multi-function I/O port block.
  Assumes a single 125 MHz bus clock, an AHB-Lite master and pins sampled through
  two-flop synchronisers inside the block.
*/
// Functional notes
// - Port A: eight pins, each direction bit 0 input, 1 drives latch bit.
// - Port A segment-select 1 gives pin to LCD driver, overriding direction and latch.
// - Reset clears port A latch, direction and segment-select to zero.
// - Port A read returns pin level when direction 0 and segment 0.
// - Port A read returns 0 when direction 0 and segment 1.
// - Port A read returns latch bit when direction is 1.
// - Port A registers at indices 005h, 00Ah, F9Fh; eight bits, read/write.
// - Port B: eight pins, direction 1 drives latch, 0 releases for input.
// - Port B input-enable gates digital input; 0 frees pin for analog or wake-up.
// - Reset clears port B latch and direction, sets input-enable to all ones.
// - Port B read returns 0 when direction 0 and input-enable 0.
// - Port B read returns pin level when direction 0 and input-enable 1.
// - Port B read returns latch bit when direction 1, whatever input-enable.
// - Converter channel comes from its own select field, not port bits.
// - Read-modify-write copies pin level into latch bits of input pins; port A segment bits and port B disabled input bits copy 0.
package dmio_pkg;

  localparam int          PORT_W     = 8;
  localparam int          IDX_W      = 12;
  localparam int          ADDR_LSB   = 2;
  localparam int          CHSEL_W    = 3;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_PA_LATCH = 12'h005;
  localparam logic [11:0] IDX_PA_DIR   = 12'h00a;
  localparam logic [11:0] IDX_PA_SEG   = 12'hf9f;
  localparam logic [11:0] IDX_PB_LATCH = 12'h006;
  localparam logic [11:0] IDX_PB_DIR   = 12'h00b;
  localparam logic [11:0] IDX_PB_IE    = 12'h00c;
  localparam logic [11:0] IDX_CONV     = 12'h0e0;

  localparam logic [7:0]  RST_PA_LATCH = 8'h00;
  localparam logic [7:0]  RST_PA_DIR   = 8'h00;
  localparam logic [7:0]  RST_PA_SEG   = 8'h00;
  localparam logic [7:0]  RST_PB_LATCH = 8'h00;
  localparam logic [7:0]  RST_PB_DIR   = 8'h00;
  localparam logic [7:0]  RST_PB_IE    = 8'hff;
  localparam logic [2:0]  RST_CHSEL    = 3'h0;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  typedef enum logic [2:0] {
    DMIO_SEL_NONE     = 3'b000,
    DMIO_SEL_PA_LATCH = 3'b001,
    DMIO_SEL_PA_DIR   = 3'b010,
    DMIO_SEL_PA_SEG   = 3'b011,
    DMIO_SEL_PB_LATCH = 3'b100,
    DMIO_SEL_PB_DIR   = 3'b101,
    DMIO_SEL_PB_IE    = 3'b110,
    DMIO_SEL_CONV     = 3'b111
  } dmio_sel_t;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe;
  } dmio_pins_t;

  typedef struct packed {
    logic [7:0]  pa_latch;
    logic [7:0]  pa_dir;
    logic [7:0]  pa_seg;
    logic [7:0]  pb_latch;
    logic [7:0]  pb_dir;
    logic [7:0]  pb_ie;
    logic [2:0]  chsel;
    logic [7:0]  pa_sync1;
    logic [7:0]  pa_sync2;
    logic [7:0]  pb_sync1;
    logic [7:0]  pb_sync2;
    logic        ph_write;
    dmio_sel_t   ph_sel;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    dmio_pins_t  pa_pins;
    dmio_pins_t  pb_pins;
    logic [7:0]  pb_digital_in;
    logic [7:0]  pb_analog_sel;
  } dmio_state_t;

endpackage

/* sim/dmio_sva.sv */
/*
  Checker for the dual I/O port block: bus writes against pin outputs and readback.
  Assumes it sees only the top ports and is attached by the bind at the foot.
*/
`timescale 1ns/100ps
module dmio_sva #(
  parameter int PORT_W = 8
) (
  input wire logic                 hclk,          // Bus clock
  input wire logic                 hresetn,       // Reset, active low
  input wire logic                 hsel,          // Slave select
  input wire logic [31:0]          haddr,         // Byte address
  input wire logic [1:0]           htrans,        // Transfer type
  input wire logic                 hwrite,        // Write
  input wire logic [31:0]          hwdata,        // Write data
  input wire logic                 hready,        // Bus ready
  input wire logic                 hreadyout,     // Slave ready
  input wire logic [31:0]          hrdata,        // Read data
  input wire logic                 hresp,         // Response
  input wire logic [7:0]           lcd_seg_data,  // Segment levels
  input dmio_pkg::dmio_pins_t      pa_pin,        // Port A pins
  input dmio_pkg::dmio_pins_t      pb_pin,        // Port B pins
  input wire logic [7:0]           pb_digital_in, // Gated input
  input wire logic [7:0]           pb_analog_sel, // Analog release
  input wire logic [2:0]           converter_channel_select // Channel
);
  localparam logic [31:0] A_PAD = {18'h0, dmio_pkg::IDX_PA_DIR, 2'h0};
  localparam logic [31:0] A_PAS = {18'h0, dmio_pkg::IDX_PA_SEG, 2'h0};
  localparam logic [31:0] A_PBL = {18'h0, dmio_pkg::IDX_PB_LATCH, 2'h0};
  localparam logic [31:0] A_PBI = {18'h0, dmio_pkg::IDX_PB_IE, 2'h0};
  localparam logic [31:0] A_CNV = {18'h0, dmio_pkg::IDX_CONV, 2'h0};
  logic tk;
  assign tk = hsel & hready & htrans[1];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_reset_pins_idle: assert property ($rose(hresetn) |-> pa_pin.oe == 8'h00 && pb_pin.oe == 8'h00
    && pb_analog_sel == 8'h00) else $error("pins not idle after reset");
  a_pa_dir_drive: assert property (tk && hwrite && haddr == A_PAD |=> ##1
    (pa_pin.oe & $past(hwdata[7:0])) == $past(hwdata[7:0])) else $error("port A enable missing");
  a_seg_lcd_owns: assert property (tk && hwrite && haddr == A_PAS |=> ##1
    (pa_pin.oe & $past(hwdata[7:0])) == $past(hwdata[7:0])
    && (pa_pin.drive & $past(hwdata[7:0])) == ($past(lcd_seg_data) & $past(hwdata[7:0])))
    else $error("segment pin not driven by lcd");
  a_pb_latch_out: assert property (tk && hwrite && haddr == A_PBL |=> ##1
    pb_pin.drive == $past(hwdata[7:0])) else $error("port B drive wrong");
  a_ie_release: assert property (tk && hwrite && haddr == A_PBI |=> ##1
    (pb_analog_sel & $past(hwdata[7:0])) == 8'h00) else $error("enabled pin released");
  a_gate_disjoint: assert property ((pb_digital_in & pb_analog_sel) == 8'h00)
    else $error("pin both digital and analog");
  a_rd_after_wr: assert property (tk && hwrite && haddr == A_PAS ##1 tk && !hwrite && haddr == A_PAS
    |=> hrdata[7:0] == $past(hwdata[7:0])) else $error("readback stale");
  a_chan_select: assert property (tk && hwrite && haddr == A_CNV |=> ##1
    converter_channel_select == $past(hwdata[2:0])) else $error("channel wrong");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  a_zero_wait: assert property (hreadyout && hresp == dmio_pkg::HRESP_OKAY)
    else $error("wait or error response");
  c_seg_write: cover property (tk && hwrite && haddr == A_PAS);
  c_analog_use: cover property (pb_analog_sel != 8'h00);
  c_digital_use: cover property (pb_digital_in != 8'h00);
endmodule

bind dmio_top dmio_sva #(.PORT_W(PORT_W)) i_dmio_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lcd_seg_data(lcd_seg_data),
  .pa_pin(pa_pin), .pb_pin(pb_pin), .pb_digital_in(pb_digital_in), .pb_analog_sel(pb_analog_sel),
  .converter_channel_select(converter_channel_select));

/* sim/dmio_pin_model.sv */
/*
  Outside circuitry on both ports and the LCD segment driver.
  Assumes outside drivers are weaker than the block: an enabled pin shows the block's level.
*/
`timescale 1ns/100ps
module dmio_pin_model (
  input dmio_pkg::dmio_pins_t pa_pin,       // Port A drive from block
  input dmio_pkg::dmio_pins_t pb_pin,       // Port B drive from block
  input wire logic [7:0]      ext_a,        // Outside levels, port A
  input wire logic [7:0]      ext_b,        // Outside levels, port B
  input wire logic [7:0]      lcd_pat,      // Segment pattern
  output logic [7:0]          pa_pin_in,    // Resolved port A wire
  output logic [7:0]          pb_pin_in,    // Resolved port B wire
  output logic [7:0]          lcd_seg_data  // Segment levels to block
);
  assign pa_pin_in = (pa_pin.oe & pa_pin.drive) | (~pa_pin.oe & ext_a);
  assign pb_pin_in = (pb_pin.oe & pb_pin.drive) | (~pb_pin.oe & ext_b);
  assign lcd_seg_data = lcd_pat;
endmodule

/* sim/dmio_tb.sv */
/*
  Self-checking bench for the dual I/O port block over AHB-Lite.
  Assumes the pin model resolves the wires and the checker is bound to the top.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module testbench;
  localparam logic [31:0] A_PAL = {18'h0, dmio_pkg::IDX_PA_LATCH, 2'h0};
  localparam logic [31:0] A_PAD = {18'h0, dmio_pkg::IDX_PA_DIR, 2'h0};
  localparam logic [31:0] A_PAS = {18'h0, dmio_pkg::IDX_PA_SEG, 2'h0};
  localparam logic [31:0] A_PBL = {18'h0, dmio_pkg::IDX_PB_LATCH, 2'h0};
  localparam logic [31:0] A_PBD = {18'h0, dmio_pkg::IDX_PB_DIR, 2'h0};
  localparam logic [31:0] A_PBI = {18'h0, dmio_pkg::IDX_PB_IE, 2'h0};
  localparam logic [31:0] A_CNV = {18'h0, dmio_pkg::IDX_CONV, 2'h0};
  logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata, rd;
  logic [1:0]           htrans;
  logic [2:0]           hsize, chan;
  logic [7:0]           ext_a, ext_b, lcd_pat, pa_in, pb_in, lcd, dig, ana;
  dmio_pkg::dmio_pins_t pa_pin, pb_pin;
  int                   error_cnt, comparisons;
  dmio_top i_dmio_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pa_pin_in(pa_in), .pa_pin(pa_pin), .lcd_seg_data(lcd),
    .pb_pin_in(pb_in), .pb_pin(pb_pin), .pb_digital_in(dig), .pb_analog_sel(ana),
    .converter_channel_select(chan));
  dmio_pin_model i_dmio_pin_model (.pa_pin(pa_pin), .pb_pin(pb_pin), .ext_a(ext_a), .ext_b(ext_b),
    .lcd_pat(lcd_pat), .pa_pin_in(pa_in), .pb_pin_in(pb_in), .lcd_seg_data(lcd));
  // ********************
  // Bus master tasks
  // ********************
  // Read right at the rising edge: the design's flops have not updated there yet
  task automatic wait_rdy();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= dmio_pkg::HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  // Write whose data phase overlaps a read of the same place
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= dmio_pkg::HTRANS_NONSEQ;
    wait_rdy();
    hwrite <= 1'b0;
    hwdata <= d;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(nm, e, rd)
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic reset_checks();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("pa_dir", A_PAD, 32'h0);
    rchk("pa_seg", A_PAS, 32'h0);
    rchk("pb_dir", A_PBD, 32'h0);
    rchk("pb_ie", A_PBI, 32'hff);
    rchk("conv", A_CNV, 32'h0);
    `CHK("pins_oe", 16'h0, {pa_pin.oe, pb_pin.oe})
    xfer(A_PAD, 1'b1, 32'hff);
    rchk("pa_latch", A_PAL, 32'h0);
    xfer(A_PBD, 1'b1, 32'hff);
    rchk("pb_latch", A_PBL, 32'h0);
  endtask
  task automatic port_a(input logic [7:0] l, input logic [7:0] d, input logic [7:0] s);
    xfer(A_PAL, 1'b1, {24'h0, l});
    xfer(A_PAD, 1'b1, {24'h0, d});
    xfer(A_PAS, 1'b1, {24'h0, s});
    rchk("pa_read", A_PAL, {24'h0, (d & l) | (~d & ~s & ext_a)});
    `CHK("pa_oe", d | s, pa_pin.oe)
    `CHK("pa_drive", (s & lcd_pat) | (~s & l), pa_pin.drive)
  endtask
  task automatic port_b(input logic [7:0] l, input logic [7:0] d, input logic [7:0] e);
    xfer(A_PBL, 1'b1, {24'h0, l});
    xfer(A_PBD, 1'b1, {24'h0, d});
    xfer(A_PBI, 1'b1, {24'h0, e});
    rchk("pb_read", A_PBL, {24'h0, (d & l) | (~d & e & ext_b)});
    `CHK("pb_pins", {d, l}, {pb_pin.oe, pb_pin.drive})
    `CHK("pb_gates", {~d & ~e, ~d & e & ext_b}, {ana, dig})
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    final_report();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {ext_a, ext_b, lcd_pat} = {8'hc3, 8'h5a, 8'ha5};
    error_cnt = 0;
    comparisons = 0;
    reset_checks();
    port_a(8'h96, 8'hf0, 8'h3c);
    port_a(8'h69, 8'h0f, 8'hf0);
    port_b(8'h13, 8'h0f, 8'h55);
    port_b(8'h0c, 8'hc3, 8'h0f);
    // Input bits pick up the pin level through a read-back-write
    xfer(A_PAS, 1'b1, 32'h0);
    xfer(A_PAL, 1'b1, 32'h05);
    xfer(A_PAD, 1'b1, 32'h0f);
    xfer(A_PAL, 1'b0, 32'h0);
    xfer(A_PAL, 1'b1, rd);
    xfer(A_PAD, 1'b1, 32'hff);
    rchk("pa_rmw", A_PAL, {24'h0, (ext_a & 8'hf0) | 8'h05});
    wr_rd(A_PAS, 32'h5a);
    `CHK("seg_back", 32'h5a, rd)
    xfer(A_CNV, 1'b1, 32'hfffffffd);
    rchk("conv_rd", A_CNV, 32'h5);
    `CHK("chan", 3'h5, chan)
    xfer(32'h40, 1'b1, 32'hff);
    rchk("unmapped", 32'h40, 32'h0);
    rchk("alias", A_PAD | 32'h4000, 32'h0);
    reset_checks();
    final_report();
  end
endmodule
